// File: verilog/ddr2_pin_params.svh
// Offsets, field positions and reset values of the DDR2 pin front end.
`ifndef DDR2_PIN_PARAMS_SVH
`define DDR2_PIN_PARAMS_SVH
`define OFS_STATUS 4'h0
`define OFS_CTRL 4'h4
`define OFS_MODE 4'h8
`define OFS_EXT1 4'hC
`define CTRL_X8_BIT 0
`define BA_MODE 2'h0
`define BA_EXT1 2'h1
`define BA_EXT2 2'h2
`define BA_EXT3 2'h3
`define A_PRE_ALL 10
`define EXT1_RTT0 2
`define EXT1_RTT1 6
`define EXT1_DQSN_OFF 10
`define EXT1_RDQS_EN 11
`define BURST_BEATS_DEF 4
`define MODE_RST 13'h0000
`define SYNC_W 25
`endif

// File: verilog/ddr2_pin_pkg.sv
// Types shared by the DDR2 pin front end and its command decoder.
package ddr2_pin_pkg;
   typedef enum logic [3:0] {
      PWR_ON = 4'h1,
      PWR_PPD = 4'h2,
      PWR_APD = 4'h4,
      PWR_SREF = 4'h8
   } pwr_e;
   typedef enum logic [2:0] {
      CMD_NOP = 3'h0,
      CMD_ACT = 3'h1,
      CMD_RD = 3'h2,
      CMD_WR = 3'h3,
      CMD_PRE = 3'h4,
      CMD_REF = 3'h5,
      CMD_MRS = 3'h6
   } cmd_e;

   // Maps the active-low row, column and write strobes to a command.
   function automatic cmd_e cmd_of(input logic ras_b, input logic cas_b,
                                   input logic we_b);
      cmd_e c;
      c = CMD_NOP;
      unique case ({ras_b, cas_b, we_b})
         3'b011: c = CMD_ACT;
         3'b101: c = CMD_RD;
         3'b100: c = CMD_WR;
         3'b010: c = CMD_PRE;
         3'b001: c = CMD_REF;
         3'b000: c = CMD_MRS;
         default: c = CMD_NOP;
      endcase
      return c;
   endfunction
endpackage

// File: verilog/cmd_if.sv
// Decoded command carried from the decoder to the pin front end.
`timescale 1ns/1ps
interface cmd_if;
   import ddr2_pin_pkg::*;
   logic valid;
   cmd_e cmd;
   logic [1:0] bank;
   logic [12:0] addr;
   modport src (output valid, output cmd, output bank, output addr);
   modport snk (input valid, input cmd, input bank, input addr);
endinterface

// File: verilog/cmd_decode.sv
// Command decoder for one sampled clock crossing.
`timescale 1ns/1ps
module cmd_decode
   import ddr2_pin_pkg::*;
(
   input wire logic take_i,
   input wire logic cs_b_i,
   input wire logic ras_b_i,
   input wire logic cas_b_i,
   input wire logic we_b_i,
   input wire logic [1:0] ba_i,
   input wire logic [12:0] addr_i,
   cmd_if.src cmd_o
);
   // A deselected rank sees a no-operation, so nothing downstream moves.
   always_comb begin
      cmd_o.cmd = cmd_of(ras_b_i, cas_b_i, we_b_i);
      cmd_o.valid = take_i && !cs_b_i && (cmd_o.cmd != CMD_NOP);
      cmd_o.bank = ba_i;
      cmd_o.addr = addr_i;
   end
endmodule

// File: verilog/ddr2_pin_front.sv
// DDR2 command, address and control pin front end with a register slave.
//
// Notes on behaviour
// - Address and control are taken where CK rises and CK# falls.
// - Read beats follow both directions of differential clock crossing.
// - CKE high runs clocks, buffers and drivers; CKE low stops them.
// - CKE low: idle banks give precharge power-down or self refresh.
// - CKE synchronous for entries and power-down exit; self-refresh exit async.
// - Power-down keeps clock, ODT, CKE buffers; self refresh only CKE.
// - Commands are ignored on an edge where CS# is high.
// - Command comes from RAS#, CAS#, WE# with CS#.
// - Registered ODT high enables termination on data, strobe, mask lines.
// - ODT is ignored when the extended mode register disables termination.
// - DM sampled on both DQS edges; masked beats stay unwritten.
// - On x8 the shared pin is write mask or read strobe.
// - Active, Read, Write, single Precharge target the bank-address bank.
// - On mode set, bank address chooses mode or extended register.
// - Active takes row; Read, Write take column plus auto-precharge.
// - Precharge closes selected bank with A10 low, all with A10 high.
// - Mode set loads the op-code from the address inputs.
// - Extended bit A10 drops complementary strobes; A11 adds x8 read strobe.
// - Read strobe is edge aligned; controller centres write strobe.
`timescale 1ns/1ps
`include "ddr2_pin_params.svh"
module ddr2_pin_front
   import ddr2_pin_pkg::*;
#(
   parameter int BURST_BEATS = `BURST_BEATS_DEF,
   parameter bit X8_DEFAULT = 1'b0
)(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic ck_i,
   input wire logic ck_b_i,
   input wire logic cke_i,
   input wire logic cs_b_i,
   input wire logic ras_b_i,
   input wire logic cas_b_i,
   input wire logic we_b_i,
   input wire logic odt_i,
   input wire logic [1:0] ba_i,
   input wire logic [12:0] addr_i,
   input wire logic dm_i,
   input wire logic dqs_i,
   output logic clk_run_o,
   output logic [3:0] pwr_state_o,
   output logic cmd_valid_o,
   output logic [2:0] cmd_code_o,
   output logic [1:0] cmd_bank_o,
   output logic [12:0] row_addr_o,
   output logic [11:0] col_addr_o,
   output logic auto_pre_o,
   output logic [3:0] bank_open_o,
   output logic odt_term_o,
   output logic rd_beat_o,
   output logic dqs_o,
   output logic dqs_oe_b_o,
   output logic dqs_n_oe_b_o,
   output logic rdqs_oe_b_o,
   output logic wr_beat_o,
   output logic wr_keep_o
);
   logic [`SYNC_W-1:0] meta_q;
   logic [`SYNC_W-1:0] sync_q;
   logic ck_s, ckb_s, cke_s, cs_s, ras_s, cas_s, we_s, odt_s, dm_s, dqs_s;
   logic [1:0] ba_s;
   logic [12:0] addr_s;
   logic hi_q, lo_q, dqs_prev_q;
   logic rise, fall, dqs_edge, take;
   cmd_if cmd_bus ();

   // Every pin passes two flops; the first is read only by the second.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= {ck_i, ck_b_i, cke_i, cs_b_i, ras_b_i, cas_b_i, we_b_i,
                    odt_i, ba_i, addr_i, dm_i, dqs_i};
         sync_q <= meta_q;
      end
   end

   // Unpack the synchronised pins; equal depth keeps them aligned.
   assign {ck_s, ckb_s, cke_s, cs_s, ras_s, cas_s, we_s, odt_s, ba_s,
           addr_s, dm_s, dqs_s} = sync_q;

   // Clock crossing detection in both directions.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hi_q <= 1'b0;
         lo_q <= 1'b0;
         dqs_prev_q <= 1'b0;
      end else begin
         hi_q <= ck_s && !ckb_s;
         lo_q <= !ck_s && ckb_s;
         dqs_prev_q <= dqs_s;
      end
   end
   assign rise = ck_s && !ckb_s && !hi_q;
   assign fall = !ck_s && ckb_s && !lo_q;
   assign dqs_edge = dqs_s != dqs_prev_q;

   // Register bus and software-visible state.
   logic wait_q, wait_d;
   logic [31:0] rdata_q, rdata_d;
   logic x8_q, x8_d;
   logic [12:0] mr_q, mr_d, emr1_q, emr1_d, emr2_q, emr2_d, emr3_q, emr3_d;
   pwr_e pwr_q, pwr_d;
   logic [3:0] open_q, open_d;
   logic run_q, run_d;

   // Power states: no command runs unless this edge sees CKE high and the power state is on.
   assign take = rise && cke_s && (pwr_q == PWR_ON);

   cmd_decode u_dec (
      .take_i(take),
      .cs_b_i(cs_s),
      .ras_b_i(ras_s),
      .cas_b_i(cas_s),
      .we_b_i(we_s),
      .ba_i(ba_s),
      .addr_i(addr_s),
      .cmd_o(cmd_bus)
   );

   // Power-down is entered and left on a clock crossing; self refresh
   // is left as soon as CKE is seen high, since the clock may be stopped.
   always_comb begin
      pwr_d = pwr_q;
      unique case (pwr_q)
         PWR_ON: begin
            if (rise && !cke_s) begin
               if (!cs_s && cmd_of(ras_s, cas_s, we_s) == CMD_REF &&
                   open_q == 4'h0) begin
                  pwr_d = PWR_SREF;
               end else if (open_q != 4'h0) begin
                  pwr_d = PWR_APD;
               end else begin
                  pwr_d = PWR_PPD;
               end
            end
         end
         PWR_PPD, PWR_APD: begin
            if (rise && cke_s) begin
               pwr_d = PWR_ON;
            end
         end
         PWR_SREF: begin
            if (cke_s) begin
               pwr_d = PWR_ON;
            end
         end
      endcase
      run_d = pwr_d == PWR_ON;
   end

   // Bank state and mode registers follow executed commands only.
   always_comb begin
      open_d = open_q;
      mr_d = mr_q;
      emr1_d = emr1_q;
      emr2_d = emr2_q;
      emr3_d = emr3_q;
      if (cmd_bus.valid) begin
         unique case (cmd_bus.cmd)
            CMD_ACT: open_d[cmd_bus.bank] = 1'b1;
            CMD_RD, CMD_WR: begin
               if (cmd_bus.addr[`A_PRE_ALL]) begin
                  open_d[cmd_bus.bank] = 1'b0;
               end
            end
            CMD_PRE: begin
               if (cmd_bus.addr[`A_PRE_ALL]) begin
                  open_d = 4'h0;
               end else begin
                  open_d[cmd_bus.bank] = 1'b0;
               end
            end
            CMD_MRS: begin
               unique case (cmd_bus.bank)
                  `BA_MODE: mr_d = cmd_bus.addr;
                  `BA_EXT1: emr1_d = cmd_bus.addr;
                  `BA_EXT2: emr2_d = cmd_bus.addr;
                  `BA_EXT3: emr3_d = cmd_bus.addr;
               endcase
            end
            default: open_d = open_q;
         endcase
      end
   end

   // Avalon slave: one wait cycle, then the answer with waitrequest low.
   always_comb begin
      wait_d = 1'b1;
      rdata_d = rdata_q;
      x8_d = x8_q;
      if ((avs_read_i || avs_write_i) && wait_q) begin
         wait_d = 1'b0;
         rdata_d = 32'h0000_0000;
         if (avs_read_i) begin
            unique case (avs_address_i)
               `OFS_STATUS: rdata_d = {24'h00_0000, open_q, pwr_q};
               `OFS_CTRL: rdata_d = {31'h0000_0000, x8_q};
               `OFS_MODE: rdata_d = {19'h0_0000, mr_q};
               `OFS_EXT1: rdata_d = {19'h0_0000, emr1_q};
               default: rdata_d = 32'h0000_0000;
            endcase
         end
      end
      if (avs_write_i && !wait_q && avs_address_i == `OFS_CTRL &&
          avs_byteenable_i[0]) begin
         x8_d = avs_writedata_i[`CTRL_X8_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
         x8_q <= X8_DEFAULT;
         pwr_q <= PWR_ON;
         run_q <= 1'b1;
         open_q <= 4'h0;
         mr_q <= `MODE_RST;
         emr1_q <= `MODE_RST;
         emr2_q <= `MODE_RST;
         emr3_q <= `MODE_RST;
      end else begin
         wait_q <= wait_d;
         rdata_q <= rdata_d;
         x8_q <= x8_d;
         pwr_q <= pwr_d;
         run_q <= run_d;
         open_q <= open_d;
         mr_q <= mr_d;
         emr1_q <= emr1_d;
         emr2_q <= emr2_d;
         emr3_q <= emr3_d;
      end
   end

   // Command capture, termination and the two data-path burst counters.
   logic cv_q, cv_d, ap_q, ap_d, term_q, term_d, rtt_on, mask_on;
   logic [2:0] code_q, code_d;
   logic [1:0] bank_q, bank_d;
   logic [12:0] row_q, row_d;
   logic [11:0] col_q, col_d;
   logic [3:0] rd_left_q, rd_left_d, wr_left_q, wr_left_d;
   logic rbeat_q, rbeat_d, dqs_q, dqs_d, oe_b_q, oe_b_d;
   logic noe_b_q, noe_b_d, roe_b_q, roe_b_d;
   logic wbeat_q, wbeat_d, keep_q, keep_d;

   assign rtt_on = emr1_q[`EXT1_RTT0] || emr1_q[`EXT1_RTT1];
   assign mask_on = !(x8_q && emr1_q[`EXT1_RDQS_EN]);

   // Burst counts assume CKE stays high through the access; a power-down
   // mid-burst clears the read counter and leaves the write counter holding.
   always_comb begin
      cv_d = cmd_bus.valid;
      code_d = code_q;
      bank_d = bank_q;
      row_d = row_q;
      col_d = col_q;
      ap_d = ap_q;
      rd_left_d = rd_left_q;
      wr_left_d = wr_left_q;
      rbeat_d = 1'b0;
      dqs_d = dqs_q;
      wbeat_d = 1'b0;
      keep_d = keep_q;
      term_d = term_q;
      if (cmd_bus.valid) begin
         code_d = cmd_bus.cmd;
         bank_d = cmd_bus.bank;
         if (cmd_bus.cmd == CMD_ACT) begin
            row_d = cmd_bus.addr;
         end
         if (cmd_bus.cmd == CMD_RD || cmd_bus.cmd == CMD_WR) begin
            col_d = {cmd_bus.addr[12:11], cmd_bus.addr[9:0]};
            ap_d = cmd_bus.addr[`A_PRE_ALL];
         end
      end
      if (rise && (pwr_q != PWR_SREF)) begin
         term_d = odt_s && rtt_on;
      end
      if (pwr_q == PWR_SREF || !rtt_on) begin
         term_d = 1'b0;
      end
      if (pwr_q == PWR_ON && (rise || fall) && rd_left_q != 4'h0) begin
         rbeat_d = 1'b1;
         dqs_d = !dqs_q;
         rd_left_d = rd_left_q - 4'h1;
      end
      if (pwr_q == PWR_ON && dqs_edge && wr_left_q != 4'h0) begin
         wbeat_d = 1'b1;
         keep_d = !(dm_s && mask_on);
         wr_left_d = wr_left_q - 4'h1;
      end
      if (cmd_bus.valid && cmd_bus.cmd == CMD_RD) begin
         rd_left_d = 4'(BURST_BEATS);
         dqs_d = 1'b0;
      end
      if (cmd_bus.valid && cmd_bus.cmd == CMD_WR) begin
         wr_left_d = 4'(BURST_BEATS);
      end
      if (pwr_d != PWR_ON) begin
         rd_left_d = 4'h0;
      end
      oe_b_d = !(rd_left_d != 4'h0 || rbeat_d);
      noe_b_d = oe_b_d || emr1_q[`EXT1_DQSN_OFF];
      roe_b_d = oe_b_d || mask_on;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cv_q <= 1'b0;
         code_q <= 3'h0;
         bank_q <= 2'h0;
         row_q <= 13'h0000;
         col_q <= 12'h000;
         ap_q <= 1'b0;
         term_q <= 1'b0;
         rd_left_q <= 4'h0;
         wr_left_q <= 4'h0;
         rbeat_q <= 1'b0;
         dqs_q <= 1'b0;
         oe_b_q <= 1'b1;
         noe_b_q <= 1'b1;
         roe_b_q <= 1'b1;
         wbeat_q <= 1'b0;
         keep_q <= 1'b0;
      end else begin
         cv_q <= cv_d;
         code_q <= code_d;
         bank_q <= bank_d;
         row_q <= row_d;
         col_q <= col_d;
         ap_q <= ap_d;
         term_q <= term_d;
         rd_left_q <= rd_left_d;
         wr_left_q <= wr_left_d;
         rbeat_q <= rbeat_d;
         dqs_q <= dqs_d;
         oe_b_q <= oe_b_d;
         noe_b_q <= noe_b_d;
         roe_b_q <= roe_b_d;
         wbeat_q <= wbeat_d;
         keep_q <= keep_d;
      end
   end

   // All outputs come straight from flops.
   assign avs_readdata_o = rdata_q;
   assign avs_waitrequest_o = wait_q;
   assign clk_run_o = run_q;
   assign pwr_state_o = pwr_q;
   assign cmd_valid_o = cv_q;
   assign cmd_code_o = code_q;
   assign cmd_bank_o = bank_q;
   assign row_addr_o = row_q;
   assign col_addr_o = col_q;
   assign auto_pre_o = ap_q;
   assign bank_open_o = open_q;
   assign odt_term_o = term_q;
   assign rd_beat_o = rbeat_q;
   assign dqs_o = dqs_q;
   assign dqs_oe_b_o = oe_b_q;
   assign dqs_n_oe_b_o = noe_b_q;
   assign rdqs_oe_b_o = roe_b_q;
   assign wr_beat_o = wbeat_q;
   assign wr_keep_o = keep_q;

   // Checks on the pin and bus behaviour; they watch design state and the bus request inputs.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   a_cs_masks_cmd: assert property (rise && cs_s |=> !cmd_valid_o)
      else $error("command taken while chip select high");
   a_act_decode: assert property (take && !cs_s && !ras_s
      && cas_s && we_s |=> cmd_valid_o && cmd_code_o == CMD_ACT
      && bank_open_o[cmd_bank_o])
      else $error("active not decoded or bank not opened");
   a_pre_all_banks: assert property (cmd_bus.valid &&
      cmd_bus.cmd == CMD_PRE && cmd_bus.addr[`A_PRE_ALL] |=> open_q == 4'h0)
      else $error("precharge all left a bank open");
   a_sref_exit: assert property (pwr_q == PWR_SREF && cke_s
      |=> pwr_q == PWR_ON ##1 clk_run_o)
      else $error("self refresh not left on CKE high");
   a_pd_no_cmd: assert property (pwr_q != PWR_ON |=> !cmd_valid_o)
      else $error("command executed while powered down");
   a_run_state: assert property (rise && !cke_s |=> !clk_run_o)
      else $error("clock run flag high after CKE seen low");
   a_odt_off: assert property (!rtt_on |=> !odt_term_o)
      else $error("termination on while disabled");
   a_rd_drive: assert property (cmd_bus.cmd == CMD_RD &&
      cmd_bus.valid && pwr_d == PWR_ON |=> !dqs_oe_b_o && !rd_beat_o)
      else $error("read strobe driver not enabled");
   a_wr_mask: assert property (pwr_q == PWR_ON && dqs_edge &&
      wr_left_q != 4'h0 && dm_s && mask_on |=> wr_beat_o && !wr_keep_o)
      else $error("masked write beat was kept");
   a_bus_answer: assert property ((avs_read_i || avs_write_i) && wait_q
      |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("register bus answer not one cycle");

   c_sref: cover property (pwr_q == PWR_ON ##1 pwr_q == PWR_SREF);
   c_apd: cover property (pwr_q == PWR_ON ##1 pwr_q == PWR_APD);
   c_masked: cover property (wr_beat_o && !wr_keep_o);
   c_pre_all: cover property (cmd_bus.valid && cmd_bus.cmd == CMD_PRE &&
      cmd_bus.addr[`A_PRE_ALL]);
endmodule

// File: tb/ddr2_ctrl_model.sv
// Behavioural DDR2 memory controller that drives the device's pins.
`timescale 1ns/1ps
module ddr2_ctrl_model (
   input wire logic clk_i,
   output logic ck_o,
   output logic ck_b_o,
   output logic cke_o,
   output logic cs_b_o,
   output logic [2:0] rcw_b_o,
   output logic odt_o,
   output logic [1:0] ba_o,
   output logic [12:0] addr_o,
   output logic dm_o,
   output logic dqs_o
);
   logic ck_run = 1'b1;

   // All pins start idle and deselected.
   initial begin
      ck_o = 1'b0;
      ck_b_o = 1'b1;
      cke_o = 1'b1;
      cs_b_o = 1'b1;
      rcw_b_o = 3'b111;
      odt_o = 1'b0;
      ba_o = 2'h0;
      addr_o = 13'h0000;
      dm_o = 1'b0;
      dqs_o = 1'b0;
   end

   // Differential clock, stopped only in self refresh and until after its exit.
   always begin
      #24;
      if (ck_run) begin
         ck_o = ~ck_o;
         ck_b_o = ~ck_o;
      end
   end

   // Pins change half a period before the rise, so they are stable around it.
   task automatic issue(input logic cs_b, input logic [2:0] rcw,
                        input logic [1:0] ba, input logic [12:0] a,
                        input logic cke);
      @(negedge ck_o);
      @(posedge clk_i);
      cke_o <= cke;
      cs_b_o <= cs_b;
      rcw_b_o <= rcw;
      ba_o <= ba;
      addr_o <= a;
      @(negedge ck_o);
      @(posedge clk_i);
      // Released lines carry the inverse, so a stale level never looks valid.
      cs_b_o <= 1'b1;
      rcw_b_o <= ~rcw;
      ba_o <= ~ba;
      addr_o <= ~a;
   endtask

   // Level pins that are not tied to a command.
   task automatic set_pin(input logic odt, input logic cke);
      @(posedge clk_i);
      odt_o <= odt;
      cke_o <= cke;
   endtask

   task automatic run_ck(input logic v);
      ck_run = v;
   endtask

   // Each strobe edge lands mid-way through its mask beat.
   task automatic wr_beats(input logic [3:0] dm_pat);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_i);
         dm_o <= dm_pat[i];
         repeat (3) @(posedge clk_i);
         dqs_o <= ~dqs_o;
         repeat (3) @(posedge clk_i);
      end
      dm_o <= ~dm_o;
   endtask
endmodule

// File: tb/dram_command_pin_interface_tb.sv
// Self-checking bench for the DDR2 command pin front end.
`timescale 1ns/1ps
`include "ddr2_pin_params.svh"
`define CHK(got, want) begin \
   samples_checked++; \
   if ((got) !== (want)) begin \
      err_count++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (got), (want)); \
   end \
end
module dram_command_pin_interface_tb
   import ddr2_pin_pkg::*;
;
   localparam int BEATS = 4;
   typedef struct {
      cmd_e code;
      logic [1:0] ba;
      logic [12:0] a;
      logic [3:0] open;
   } exp_s;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic rd = 1'b0, wr = 1'b0;
   logic [3:0] address = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] readdata;
   logic waitreq, clk_run, cmd_valid, auto_pre, odt_term, rd_beat;
   logic dqs_out, dqs_oe_b, dqs_n_oe_b, rdqs_oe_b, wr_beat, wr_keep;
   logic [3:0] pwr_state, bank_open;
   logic [2:0] cmd_code, rcw_b;
   logic [1:0] cmd_bank, ba;
   logic [12:0] row_addr, addr;
   logic [11:0] col_addr;
   logic ck, ck_b, cke, cs_b, odt, dm_pin, dqs_in;
   // Reference state of the device, kept apart from the design.
   logic [3:0] exp_open = 4'h0, exp_pwr = 4'h1;
   logic [12:0] exp_mode = `MODE_RST, exp_ext1 = 13'h0000;
   logic x8 = 1'b0;
   logic [2:0] oe_seen = 3'h0;
   int rd_cnt = 0, err_count = 0, samples_checked = 0;
   exp_s cmd_q[$];
   logic keep_q[$];

   always #2.5 clk_i = ~clk_i;

   ddr2_pin_front #(.BURST_BEATS(BEATS), .X8_DEFAULT(1'b0)) i_dut (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(address),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(4'hF), .avs_readdata_o(readdata),
      .avs_waitrequest_o(waitreq), .ck_i(ck), .ck_b_i(ck_b), .cke_i(cke),
      .cs_b_i(cs_b), .ras_b_i(rcw_b[2]), .cas_b_i(rcw_b[1]),
      .we_b_i(rcw_b[0]), .odt_i(odt), .ba_i(ba), .addr_i(addr),
      .dm_i(dm_pin), .dqs_i(dqs_in), .clk_run_o(clk_run),
      .pwr_state_o(pwr_state), .cmd_valid_o(cmd_valid),
      .cmd_code_o(cmd_code), .cmd_bank_o(cmd_bank), .row_addr_o(row_addr),
      .col_addr_o(col_addr), .auto_pre_o(auto_pre), .bank_open_o(bank_open),
      .odt_term_o(odt_term), .rd_beat_o(rd_beat), .dqs_o(dqs_out),
      .dqs_oe_b_o(dqs_oe_b), .dqs_n_oe_b_o(dqs_n_oe_b),
      .rdqs_oe_b_o(rdqs_oe_b), .wr_beat_o(wr_beat), .wr_keep_o(wr_keep));

   ddr2_ctrl_model i_ctrl (
      .clk_i(clk_i), .ck_o(ck), .ck_b_o(ck_b), .cke_o(cke), .cs_b_o(cs_b),
      .rcw_b_o(rcw_b), .odt_o(odt), .ba_o(ba), .addr_o(addr),
      .dm_o(dm_pin), .dqs_o(dqs_in));

   task automatic print_verdict();
      if (err_count == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // One bus transfer; the request holds until waitrequest is seen low.
   task automatic bus(input logic w, input logic [3:0] adr,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      address <= adr;
      wdata <= d;
      wr <= w;
      rd <= !w;
      do begin
         @(posedge clk_i);
         n++;
      end while (waitreq !== 1'b0);
      q = readdata;
      `CHK(n, 2)
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rchk(input logic [3:0] adr, input logic [31:0] want);
      logic [31:0] q;
      bus(1'b0, adr, 32'h0000_0000, q);
      `CHK(q, want)
   endtask

   // Predicts the device's reaction, then drives the command onto the pins.
   task automatic cmd(input cmd_e c, input logic cs_b, input logic [1:0] b,
                      input logic [12:0] a, input logic ke);
      logic [2:0] pins;
      exp_s e;
      case (c)
         CMD_ACT: pins = 3'b011;
         CMD_RD: pins = 3'b101;
         CMD_WR: pins = 3'b100;
         CMD_PRE: pins = 3'b010;
         CMD_REF: pins = 3'b001;
         CMD_MRS: pins = 3'b000;
         default: pins = 3'b111;
      endcase
      if (exp_pwr != 4'h1) begin
         if (ke) exp_pwr = 4'h1;
      end else if (!ke) begin
         if (c == CMD_REF && !cs_b && exp_open == 4'h0) exp_pwr = 4'h8;
         else exp_pwr = (exp_open != 4'h0) ? 4'h4 : 4'h2;
      end else if (!cs_b && c != CMD_NOP) begin
         case (c)
            CMD_ACT: exp_open[b] = 1'b1;
            CMD_RD, CMD_WR: if (a[10]) exp_open[b] = 1'b0;
            CMD_PRE: if (a[10]) exp_open = 4'h0; else exp_open[b] = 1'b0;
            CMD_MRS: begin
               if (b == `BA_MODE) exp_mode = a;
               if (b == `BA_EXT1) exp_ext1 = a;
            end
            default: ;
         endcase
         e = '{c, b, a, exp_open};
         cmd_q.push_back(e);
      end
      i_ctrl.issue(cs_b, pins, b, a, ke);
      `CHK(pwr_state, exp_pwr)
      `CHK(clk_run, (exp_pwr == 4'h1))
      `CHK(bank_open, exp_open)
      `CHK(cmd_q.size(), 0)
   endtask

   // Every executed command and every beat is matched against the model.
   always @(posedge clk_i) begin
      exp_s e;
      logic kb;
      if (cmd_valid === 1'b1) begin
         if (cmd_q.size() == 0) `CHK(cmd_valid, 1'b0)
         else begin
            e = cmd_q.pop_front();
            `CHK(cmd_code, e.code)
            `CHK(cmd_bank, e.ba)
            `CHK(bank_open, e.open)
            if (e.code == CMD_ACT) `CHK(row_addr, e.a)
            if (e.code inside {CMD_RD, CMD_WR}) begin
               `CHK(col_addr, {e.a[12:11], e.a[9:0]})
               `CHK(auto_pre, e.a[10])
            end
         end
      end
      if (rd_beat === 1'b1) begin
         rd_cnt++;
         `CHK(dqs_out, rd_cnt[0])
      end
      if (dqs_oe_b === 1'b0) oe_seen[0] = 1'b1;
      if (dqs_n_oe_b === 1'b0) oe_seen[1] = 1'b1;
      if (rdqs_oe_b === 1'b0) oe_seen[2] = 1'b1;
      if (wr_beat === 1'b1) begin
         if (keep_q.size() == 0) `CHK(wr_beat, 1'b0)
         else begin
            kb = keep_q.pop_front();
            `CHK(wr_keep, kb)
         end
      end
   end

   // A hang ends the run through the same verdict.
   initial begin
      #200000;
      err_count++;
      print_verdict();
   end

   initial begin
      logic [31:0] r;
      logic [1:0] b;
      logic [12:0] a;
      logic [3:0] dm;
      void'($urandom(16));
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      @(posedge clk_i);
      `CHK(pwr_state, 4'h1)
      `CHK({waitreq, dqs_oe_b, dqs_n_oe_b, rdqs_oe_b}, 4'hF)
      repeat (3) @(posedge clk_i);
      rchk(4'h2, 32'h0000_0000);
      // Each pass covers one organisation and strobe mode setting.
      for (int k = 0; k < 4; k++) begin
         x8 = k[0];
         r = $urandom();
         r[0] = x8;
         bus(1'b1, `OFS_CTRL, r, r);
         rchk(`OFS_CTRL, {31'h0, x8});
         a = 13'($urandom());
         a[2] = 1'b1;
         a[10] = k[0];
         a[11] = k[1];
         cmd(CMD_MRS, 1'b0, `BA_EXT1, a, 1'b1);
         cmd(CMD_MRS, 1'b0, `BA_MODE, 13'($urandom()), 1'b1);
         cmd(CMD_MRS, 1'b0, `BA_EXT2, 13'($urandom()), 1'b1);
         cmd(CMD_MRS, 1'b1, `BA_MODE, ~exp_mode, 1'b1);
         rchk(`OFS_MODE, {19'h0, exp_mode});
         rchk(`OFS_EXT1, {19'h0, exp_ext1});
         b = 2'($urandom());
         cmd(CMD_ACT, 1'b0, b, 13'($urandom()), 1'b1);
         cmd(CMD_ACT, 1'b1, b + 2'h1, 13'h1FFF, 1'b1);
         a = 13'($urandom());
         a[10] = 1'b0;
         rd_cnt = 0;
         oe_seen = 3'h0;
         cmd(CMD_RD, 1'b0, b, a, 1'b1);
         repeat (3) @(posedge ck);
         repeat (8) @(posedge clk_i);
         `CHK(rd_cnt, BEATS)
         `CHK(oe_seen, {x8 & exp_ext1[11], ~exp_ext1[10], 1'b1})
         dm = 4'($urandom());
         for (int i = 0; i < BEATS; i++) begin
            keep_q.push_back(!(dm[i] && !(x8 && exp_ext1[11])));
         end
         a = 13'($urandom());
         a[10] = k[0];
         cmd(CMD_WR, 1'b0, b, a, 1'b1);
         i_ctrl.wr_beats(dm);
         repeat (6) @(posedge clk_i);
         `CHK(keep_q.size(), 0)
         cmd(CMD_PRE, 1'b0, b ^ 2'(k), {2'h0, k[1], 10'h000}, 1'b1);
         rchk(`OFS_STATUS, {24'h0, exp_open, exp_pwr});
      end
      // Power-down entries and exits, with a command ignored meanwhile.
      cmd(CMD_NOP, 1'b1, 2'h0, 13'h0000, 1'b0);
      cmd(CMD_ACT, 1'b0, 2'h1, 13'h0ABC, 1'b0);
      cmd(CMD_NOP, 1'b1, 2'h0, 13'h0000, 1'b1);
      cmd(CMD_ACT, 1'b0, 2'h2, 13'h1234, 1'b1);
      cmd(CMD_NOP, 1'b1, 2'h0, 13'h0000, 1'b0);
      rchk(`OFS_STATUS, {24'h0, exp_open, exp_pwr});
      cmd(CMD_NOP, 1'b1, 2'h0, 13'h0000, 1'b1);
      cmd(CMD_PRE, 1'b0, 2'h3, 13'h0000, 1'b1);
      cmd(CMD_PRE, 1'b0, 2'h2, 13'h0400, 1'b1);
      cmd(CMD_REF, 1'b0, 2'h0, 13'h0000, 1'b1);
      cmd(CMD_REF, 1'b0, 2'h0, 13'h0000, 1'b0);
      // Self refresh is left with the clock pair stopped.
      i_ctrl.run_ck(1'b0);
      repeat (10) @(posedge clk_i);
      `CHK(pwr_state, 4'h8)
      i_ctrl.set_pin(1'b0, 1'b1);
      repeat (20) @(posedge clk_i);
      `CHK(pwr_state, 4'h1)
      exp_pwr = 4'h1;
      i_ctrl.run_ck(1'b1);
      i_ctrl.set_pin(1'b1, 1'b1);
      repeat (2) @(posedge ck);
      repeat (6) @(posedge clk_i);
      `CHK(odt_term, 1'b1)
      cmd(CMD_MRS, 1'b0, `BA_EXT1, 13'h0000, 1'b1);
      repeat (2) @(posedge ck);
      repeat (6) @(posedge clk_i);
      `CHK(odt_term, 1'b0)
      `CHK(cmd_q.size(), 0)
      print_verdict();
   end
endmodule
